// >>> rcc_regs.vh
`ifndef RCC_REGS_VH
`define RCC_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RCC_ADR_VSET   5'h00
`define RCC_ADR_STATE  5'h01
`define RCC_ADR_GPO    5'h02
`define RCC_ADR_PMTRIG 5'h1C
`define RCC_ADR_USID   5'h1F
// ----------------------------------------
// Field positions
// ----------------------------------------
`define RCC_VSET_MSB  6
`define RCC_FLD2_MSB  7
`define RCC_FLD2_LSB  6
`define RCC_GENERAL_OUTPUT_ZERO_BIT  7
`define RCC_GENERAL_OUTPUT_ONE_BIT  6
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RCC_VSET_RST  7'h08
`define RCC_STATE_RST 2'h1
`define RCC_GPO_RST   2'h0
`define RCC_PWR_RST   2'h0
// Arbitrary upper nibble of the slave id register
`define RCC_IDHI_RST  4'h0
// ----------------------------------------
// Addresses, codes and thresholds
// ----------------------------------------
`define RCC_USID      4'h5
`define RCC_GSID      4'h0
`define RCC_VSET_LOW  7'h00
`define RCC_VSET_STBY 7'h02
`define RCC_VSET_TH1  7'h29
`define RCC_VSET_TH2  7'h39
`define RCC_SC_PFM    2'h0
`define RCC_SC_AUTO1  2'h1
`define RCC_SC_AUTO2  2'h2
`define RCC_SC_PWM    2'h3
`define RCC_PM_NORM   2'h0
`define RCC_PM_DEF    2'h1
`define RCC_PM_LOW    2'h2
`define RCC_CMD_WR    3'h2
`define RCC_CMD_RD    3'h3
// ----------------------------------------
// Frame bit counts (falling edges)
// ----------------------------------------
`define RCC_CNT_CMD   5'h0C
`define RCC_CNT_WPAR  5'h15
`define RCC_CNT_RDRV  5'h0E
`define RCC_CNT_REND  5'h17
`endif

// >>> rcc_ctrl.v
// How it works
// - State code 00 forces PFM, 11 forces PWM
// - Digital code 01: PWM at voltage code >=29h
// - Digital code 10: PWM >=39h or heavy load
// - Analog code 01: PWM when control above 0.5V
// - Analog code 10: PWM above 0.7V or load
// - Supply reference rise enables slave, loads defaults
// - Supply reference low asynchronously powers down
// - Driver launches data on clock rising edge
// - Data sampled on clock falling edge
// - Slave only, never starts a transfer
// - Broadcast address 0000b accepts writes, reads unanswered
// - Own address 0101b, group address 0000b
// - Register-zero write, register write, register read
// - Code 00h low power, 02h standby in normal power mode
// - Voltage code in bits 6:0, bit 7 zero
// - Voltage code write takes effect immediately
// - Register 02h bits 7,6 drive general outputs
// - Register 1Ch bits 7:6 select power mode
// - Leaving low power keeps programmed values
`timescale 1ns/1ps
`default_nettype none
`include "rcc_regs.vh"
module rcc_ctrl (
  // Clock and reset
  input  wire       i_sys_clk,
  input  wire       i_nrst,
  input  wire       i_vio,
  // Serial bus
  input  wire       i_sclk,
  input  wire       i_sdata,
  output wire       o_sdata,
  output wire       o_sdata_oe,
  // Analog status
  input  wire       i_analog_mode,
  input  wire       i_analog_control_voltage_above_0p5,
  input  wire       i_analog_control_voltage_above_0p7,
  input  wire       i_load_above_130,
  input  wire       i_load_below_100,
  // Converter control
  output wire [6:0] o_output_voltage_code,
  output wire       o_pwm_mode,
  output wire       o_low_power,
  output wire       o_standby,
  output wire       o_power_down,
  output wire       o_general_output_zero,
  output wire       o_general_output_one
);
  // ----------------------------------------
  // Reset and synchronisers
  // ----------------------------------------
  localparam NSYNC = 7;
  // Supply reference low acts as asynchronous reset
  wire             rst_n = i_nrst & i_vio;
  wire [NSYNC-1:0] raw = {i_analog_mode, i_load_below_100, i_load_above_130,
                          i_analog_control_voltage_above_0p7, i_analog_control_voltage_above_0p5, i_sdata, i_sclk};
  reg  [NSYNC-1:0] meta_q;      // First stage
  reg  [NSYNC-1:0] sync_q;      // Second stage
  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
      // Two flops per asynchronous input
      always @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= raw[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate
  wire sclk   = sync_q[0];
  wire sdata  = sync_q[1];
  wire vc_lo  = sync_q[2];
  wire vc_hi  = sync_q[3];
  wire ld_hi  = sync_q[4];
  wire ld_lo  = sync_q[5];
  wire analog = sync_q[6];
  reg  sclk_p_q;                // Previous clock level
  reg  sdat_p_q;                // Previous data level
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_p_q <= 1'b0;
      sdat_p_q <= 1'b0;
    end else begin
      sclk_p_q <= sclk;
      sdat_p_q <= sdata;
    end
  end
  // Edges of the synchronised bus clock
  wire sc_rise = sclk & ~sclk_p_q;
  wire sc_fall = ~sclk & sclk_p_q;
  // ----------------------------------------
  // Frame engine
  // ----------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_CMD  = 2'd1;
  localparam ST_WDAT = 2'd2;
  localparam ST_READ = 2'd3;
  reg  [1:0]  st_q;             // Frame state
  reg  [4:0]  cnt_q;            // Falling edges seen in frame
  reg  [11:0] sh_q;             // Incoming bit shifter
  reg  [4:0]  adr_q;            // Target register
  reg  [8:0]  rsh_q;            // Outgoing data and parity
  reg         sdo_q;            // Driven data level
  reg         oe_q;             // Driving data line
  reg         wr_q;             // One-cycle write strobe
  reg  [7:0]  wdat_q;           // Write data
  reg  [6:0]  vset_q;           // Output voltage code
  reg  [1:0]  state_q;          // Switching state select
  reg  [1:0]  gpo_q;            // General outputs
  reg  [1:0]  pwr_q;            // Power mode select
  // Start condition: data falls while clock low, line not ours
  wire ssc = ~sclk & sdat_p_q & ~sdata & ~oe_q;
  // Header word: address, command, parity in the newest bit
  wire [12:0] cw = {sh_q, sdata};
  // Data byte followed by its parity bit
  wire [8:0]  dw = {sh_q[7:0], sdata};
  // Own or group address selects this slave
  wire        hit = (cw[12:9] == `RCC_USID) | (cw[12:9] == `RCC_GSID);
  // Read-back value of a register
  function [7:0] rd_val;
    input [4:0] a;
    begin
      if (a == `RCC_ADR_VSET) begin
        rd_val = {1'b0, vset_q};
      end else if (a == `RCC_ADR_STATE) begin
        rd_val = {state_q, 6'h00};
      end else if (a == `RCC_ADR_GPO) begin
        rd_val = {gpo_q, 6'h00};
      end else if (a == `RCC_ADR_PMTRIG) begin
        rd_val = {pwr_q, 6'h00};
      end else if (a == `RCC_ADR_USID) begin
        rd_val = {`RCC_IDHI_RST, `RCC_USID};
      end else begin
        rd_val = 8'h00;
      end
    end
  endfunction
  // Slave engine; reacts only to master-started frames
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= ST_IDLE;
      cnt_q  <= 5'h00;
      sh_q   <= 12'h000;
      adr_q  <= 5'h00;
      rsh_q  <= 9'h000;
      sdo_q  <= 1'b0;
      oe_q   <= 1'b0;
      wr_q   <= 1'b0;
      wdat_q <= 8'h00;
    end else begin
      wr_q <= 1'b0;
      if (ssc) begin
        // Start condition restarts the frame
        st_q  <= ST_CMD;
        cnt_q <= 5'h00;
      end else if (sc_fall) begin
        cnt_q <= cnt_q + 5'h01;
        sh_q  <= cw[11:0];
        case (st_q)
          ST_CMD: begin
            // Header complete at its parity bit
            if (cnt_q == `RCC_CNT_CMD) begin
              st_q <= ST_IDLE;
              // Odd parity over address and command
              if (hit && (^cw)) begin
                if (cw[8]) begin
                  // Register-zero write
                  wr_q   <= 1'b1;
                  adr_q  <= `RCC_ADR_VSET;
                  wdat_q <= {1'b0, cw[7:1]};
                end else if (cw[8:6] == `RCC_CMD_WR) begin
                  // Register write: address sits just above the parity bit
                  st_q  <= ST_WDAT;
                  adr_q <= cw[5:1];
                end else if (cw[8:6] == `RCC_CMD_RD && cw[12:9] == `RCC_USID) begin
                  // Register read: answered on the own address only
                  st_q  <= ST_READ;
                  rsh_q <= {rd_val(cw[5:1]), ~^rd_val(cw[5:1])};
                end
              end
            end
          end
          ST_WDAT: begin
            // Data byte and parity complete
            if (cnt_q == `RCC_CNT_WPAR) begin
              st_q <= ST_IDLE;
              // Odd parity, otherwise the write is dropped
              if (^dw) begin
                wr_q   <= 1'b1;
                wdat_q <= dw[8:1];
              end
            end
          end
          ST_READ: begin
            // Bus park ends: release the line
            if (cnt_q == `RCC_CNT_REND) begin
              st_q <= ST_IDLE;
              oe_q <= 1'b0;
            end
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end else if (sc_rise && st_q == ST_READ && cnt_q >= `RCC_CNT_RDRV) begin
        // Launch data, parity, then park low
        sdo_q <= rsh_q[8];
        rsh_q <= {rsh_q[7:0], 1'b0};
        oe_q  <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // Written values persist across low power
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vset_q  <= `RCC_VSET_RST;
      state_q <= `RCC_STATE_RST;
      gpo_q   <= `RCC_GPO_RST;
      pwr_q   <= `RCC_PWR_RST;
    end else if (wr_q) begin
      if (adr_q == `RCC_ADR_VSET) begin
        vset_q <= wdat_q[`RCC_VSET_MSB:0];
      end else if (adr_q == `RCC_ADR_STATE) begin
        state_q <= wdat_q[`RCC_FLD2_MSB:`RCC_FLD2_LSB];
      end else if (adr_q == `RCC_ADR_GPO) begin
        gpo_q <= {wdat_q[`RCC_GENERAL_OUTPUT_ZERO_BIT], wdat_q[`RCC_GENERAL_OUTPUT_ONE_BIT]};
      end else if (adr_q == `RCC_ADR_PMTRIG) begin
        if (wdat_q[7:6] == `RCC_PM_DEF) begin
          // Reload defaults, stay in normal mode
          vset_q  <= `RCC_VSET_RST;
          state_q <= `RCC_STATE_RST;
          gpo_q   <= `RCC_GPO_RST;
          pwr_q   <= `RCC_PM_NORM;
        end else if (wdat_q[7:6] != 2'h3) begin
          pwr_q <= wdat_q[7:6];
        end
      end
    end
  end
  // ----------------------------------------
  // Mode decision
  // ----------------------------------------
  reg  pwm_q;                   // Selected PWM mode
  reg  pwm_d;
  reg  pd_q;                    // Power-down flag
  // Level test from the voltage code or the comparators
  wire over1 = analog ? vc_lo : (vset_q >= `RCC_VSET_TH1);
  wire over2 = analog ? vc_hi : (vset_q >= `RCC_VSET_TH2);
  // PWM or PFM from state code, level and load
  always @* begin
    pwm_d = pwm_q;
    case (state_q)
      `RCC_SC_PFM: begin
        pwm_d = 1'b0;
      end
      `RCC_SC_AUTO1: begin
        pwm_d = over1;
      end
      `RCC_SC_AUTO2: begin
        // Between load thresholds the mode holds
        if (over2 | ld_hi) begin
          pwm_d = 1'b1;
        end else if (ld_lo) begin
          pwm_d = 1'b0;
        end
      end
      default: begin
        pwm_d = 1'b1;
      end
    endcase
  end
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_q <= 1'b0;
      pd_q  <= 1'b1;
    end else begin
      pwm_q <= pwm_d;
      // Power-down clears on the first edge after release
      pd_q  <= 1'b0;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_sdata               = sdo_q;
  assign o_sdata_oe            = oe_q;
  assign o_output_voltage_code = vset_q;
  assign o_pwm_mode            = pwm_q;
  assign o_low_power           = (vset_q == `RCC_VSET_LOW) | (pwr_q == `RCC_PM_LOW);
  assign o_standby             = (vset_q == `RCC_VSET_STBY) & (pwr_q == `RCC_PM_NORM);
  assign o_power_down          = pd_q;
  assign o_general_output_zero = gpo_q[1];
  assign o_general_output_one  = gpo_q[0];
endmodule
`default_nettype wire

// >>> rcc_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module rcc_ctrl_sva (
  // Clock and resets
  input wire logic       i_sys_clk,
  input wire logic       i_nrst,
  input wire logic       i_vio,
  // Bus pins
  input wire logic       i_sclk,
  input wire logic       o_sdata,
  input wire logic       o_sdata_oe,
  // Converter control
  input wire logic [6:0] o_output_voltage_code,
  input wire logic       o_low_power,
  input wire logic       o_standby,
  input wire logic       o_power_down,
  input wire logic       o_general_output_zero,
  input wire logic       o_general_output_one
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  wire        ok;   // Both resets released
  logic [7:0] hi_q; // Cycles the slave has driven the line
  assign ok = i_nrst & i_vio;
  // Length of each slave drive phase
  always @(posedge i_sys_clk or negedge ok) begin
    if (!ok) hi_q <= 8'h00;
    else if (o_sdata_oe) hi_q <= hi_q + 8'h01;
    else hi_q <= 8'h00;
  end
  sequence s_rst2;
    !ok ##1 !ok;
  endsequence
  sequence s_drive;
    o_sdata_oe [*8];
  endsequence
  property p_rst_vals;
    s_rst2 |-> o_power_down && o_output_voltage_code == 7'h08 && !o_general_output_zero
      && !o_general_output_one && !o_sdata_oe;
  endproperty
  property p_pd_release;
    $rose(ok) |=> !o_power_down;
  endproperty
  property p_oe_rise;
    disable iff (!ok) $rose(o_sdata_oe) |-> i_sclk;
  endproperty
  property p_launch;
    disable iff (!ok) o_sdata_oe && $changed(o_sdata) |-> i_sclk;
  endproperty
  property p_oe_fall;
    disable iff (!ok) $fell(o_sdata_oe) |-> !i_sclk;
  endproperty
  property p_oe_hold;
    disable iff (!ok) $rose(o_sdata_oe) |-> s_drive;
  endproperty
  property p_oe_len;
    disable iff (!ok) $fell(o_sdata_oe) |-> hi_q >= 8'd84 && hi_q <= 8'd98;
  endproperty
  property p_standby;
    disable iff (!ok) o_standby |-> o_output_voltage_code == 7'h02 && !o_low_power;
  endproperty
  property p_lowpow;
    disable iff (!ok) o_output_voltage_code == 7'h00 |-> o_low_power;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  a_pd_release: assert property (p_pd_release) else $error("power down stuck");
  a_oe_rise: assert property (p_oe_rise) else $error("drive began with clock low");
  a_launch: assert property (p_launch) else $error("data changed with clock low");
  a_oe_fall: assert property (p_oe_fall) else $error("release with clock high");
  a_oe_hold: assert property (p_oe_hold) else $error("drive phase too short");
  a_oe_len: assert property (p_oe_len) else $error("drive phase length wrong");
  a_standby: assert property (p_standby) else $error("standby without code 02h");
  a_lowpow: assert property (p_lowpow) else $error("code 00h not low power");
endmodule
bind rcc_ctrl rcc_ctrl_sva chk_u (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_vio(i_vio), .i_sclk(i_sclk),
  .o_sdata(o_sdata), .o_sdata_oe(o_sdata_oe), .o_output_voltage_code(o_output_voltage_code),
  .o_low_power(o_low_power), .o_standby(o_standby), .o_power_down(o_power_down),
  .o_general_output_zero(o_general_output_zero), .o_general_output_one(o_general_output_one));
`default_nettype wire

// >>> rcc_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bus master model
// ----------------------------------------
module rcc_bus_master (
  // Slave side of the data line
  input  wire logic i_sdata,
  input  wire logic i_sdata_oe,
  // Resolved bus pins
  output var  logic o_sclk,
  output wire logic o_line
);
  logic m_oe;   // Master drives the data line
  logic m_d;    // Master data bit
  logic last_q; // Last driven level
  // Undriven line shows the inverse of its last level
  assign o_line = i_sdata_oe ? i_sdata : (m_oe ? m_d : ~last_q);
  always @* begin
    if (i_sdata_oe || m_oe) last_q = o_line;
  end
  // Pins held low until the supply reference comes
  initial begin
    o_sclk = 1'b0;
    m_oe = 1'b1;
    m_d = 1'b0;
  end
  // One bit, launched on the rise
  task automatic cyc(input logic b);
    o_sclk = 1'b1;
    m_d = b;
    #24;
    o_sclk = 1'b0;
    #24;
  endtask
  // Start condition, then address, command and parity
  task automatic hdr(input logic [12:0] v);
    m_d = 1'b1;
    #24;
    m_d = 1'b0;
    #24;
    for (int i = 12; i >= 0; i--) cyc(v[i]);
  endtask
  task automatic byte9(input logic [8:0] v);
    for (int i = 8; i >= 0; i--) cyc(v[i]);
  endtask
  // Write frame; bad flips the header parity
  task automatic wrf(input logic [3:0] sa, input logic [7:0] cmd, input logic [7:0] d, input logic bad);
    hdr({sa, cmd, bad ^ ~^{sa, cmd}});
    if (!cmd[7]) byte9({d, ~^d});
    cyc(1'b0);
  endtask
  // Read frame; q holds data and parity
  task automatic rdf(input logic [3:0] sa, input logic [4:0] a, output logic [8:0] q);
    hdr({sa, 3'b011, a, ~^{sa, 3'b011, a}});
    cyc(1'b0);
    m_oe = 1'b0;
    for (int i = 8; i >= 0; i--) begin
      o_sclk = 1'b1;
      #24;
      q[i] = o_line;
      o_sclk = 1'b0;
      #24;
    end
    o_sclk = 1'b1;
    #24;
    o_sclk = 1'b0;
    #24;
    m_oe = 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> test_rcc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_rcc_ctrl;
  logic       sys_clk, nrst, vio, amode, v05, v07, ld130, ld100;
  wire        sclk, line, sd, sd_oe, pwm, lp, sb, pd, g0, g1;
  wire  [6:0] vset;
  int         err_total, checked, cyc_n;
  // Decision cases: state, code, mode and comparators, expected mode
  logic [14:0] tbl [12] = '{{2'h0, 7'h75, 6'b011100}, {2'h3, 7'h0A, 6'b000011}, {2'h1, 7'h28, 6'b000010},
    {2'h1, 7'h29, 6'b000011}, {2'h2, 7'h38, 6'b000010}, {2'h2, 7'h39, 6'b000011}, {2'h2, 7'h38, 6'b000101},
    {2'h1, 7'h75, 6'b100000}, {2'h1, 7'h08, 6'b110001}, {2'h2, 7'h75, 6'b100010}, {2'h2, 7'h08, 6'b101011},
    {2'h2, 7'h08, 6'b100101}};
  rcc_bus_master m_u (.i_sdata(sd), .i_sdata_oe(sd_oe), .o_sclk(sclk), .o_line(line));
  rcc_ctrl dut_u (.i_sys_clk(sys_clk), .i_nrst(nrst), .i_vio(vio), .i_sclk(sclk), .i_sdata(line), .o_sdata(sd),
    .o_sdata_oe(sd_oe), .i_analog_mode(amode), .i_analog_control_voltage_above_0p5(v05), .i_analog_control_voltage_above_0p7(v07),
    .i_load_above_130(ld130), .i_load_below_100(ld100), .o_output_voltage_code(vset), .o_pwm_mode(pwm),
    .o_low_power(lp), .o_standby(sb), .o_power_down(pd), .o_general_output_zero(g0), .o_general_output_one(g1));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic summarize();
    if (err_total == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      err_total++;
      summarize();
    end
  end
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (12) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    m_u.wrf(4'h5, {3'b010, a}, d, 1'b0);
    settle();
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [8:0] q;
    m_u.rdf(4'h5, a, q);
    chk(q, {e, ~^e});
  endtask
  initial begin
    {nrst, vio, amode, v05, v07, ld130, ld100} = 7'h00;
    repeat (8) @(negedge sys_clk);
    chk({pd, pwm, g0, g1, vset}, {4'h8, 7'h08});
    {nrst, vio} = 2'b11;
    repeat (6) @(negedge sys_clk);
    chk(pd, 1'b0);
    rd(5'h01, 8'h40);
    rd(5'h00, 8'h08);
    wr(5'h02, 8'hFF);
    chk({g0, g1}, 2'b11);
    rd(5'h02, 8'hC0);
    wr(5'h02, 8'h80);
    chk({g0, g1}, 2'b10);
    m_u.wrf(4'h0, 8'hB0, 8'h00, 1'b0);
    settle();
    chk(vset, 7'h30);
    m_u.wrf(4'h5, 8'h91, 8'h00, 1'b1);
    m_u.wrf(4'h3, 8'h91, 8'h00, 1'b0);
    settle();
    chk(vset, 7'h30);
    wr(5'h00, 8'hFF);
    rd(5'h00, 8'h7F);
    for (int k = 0; k < 12; k++) begin
      @(negedge sys_clk);
      {amode, v05, v07, ld130, ld100} = tbl[k][5:1];
      wr(5'h01, {tbl[k][14:13], 6'h00});
      wr(5'h00, {1'b0, tbl[k][12:6]});
      chk(pwm, tbl[k][0]);
    end
    {ld130, ld100} = 2'b00;
    settle();
    chk(pwm, 1'b1);
    ld100 = 1'b1;
    settle();
    chk(pwm, 1'b0);
    wr(5'h00, 8'h00);
    chk(lp, 1'b1);
    wr(5'h00, 8'h02);
    chk({sb, lp}, 2'b10);
    wr(5'h1C, 8'h80);
    chk({sb, lp}, 2'b01);
    wr(5'h1C, 8'h00);
    chk({sb, lp}, 2'b10);
    rd(5'h02, 8'h80);
    wr(5'h1C, 8'hC0);
    rd(5'h1C, 8'h00);
    wr(5'h1C, 8'h40);
    chk({g0, g1, vset}, 9'h008);
    rd(5'h01, 8'h40);
    wr(5'h02, 8'hC0);
    vio = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk({pd, g0, g1}, 3'b100);
    vio = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk(pd, 1'b0);
    rd(5'h02, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
